/* common/tccd_map.svh */
`ifndef TCCD_MAP_SVH
`define TCCD_MAP_SVH

// Clock and toggle timing
`define TCCD_CLK_NS 8
`define TCCD_PHASE_NS 30000
`define TCCD_PHASE_CYC (`TCCD_PHASE_NS / `TCCD_CLK_NS)
`define TCCD_HALF_CYC (`TCCD_PHASE_CYC / 2)
`define TCCD_TMR_W 12

// Synchroniser width and field positions in the comparator vector
`define TCCD_SYNC_W 5
`define TCCD_SYN_LVL_LO 0
`define TCCD_SYN_LVL_HI 2
`define TCCD_SYN_DAC 3
`define TCCD_SYN_VBUS 4

// Event status bits
`define TCCD_IRQ_W 4
`define TCCD_IRQ_LEVEL 0
`define TCCD_IRQ_COMP 1
`define TCCD_IRQ_VBUS 2
`define TCCD_IRQ_TOGDONE 3

// Level status codes
`define TCCD_LVL_RA 2'h0
`define TCCD_LVL_USB 2'h1
`define TCCD_LVL_1A5 2'h2
`define TCCD_LVL_3A0 2'h3

// Source current codes
`define TCCD_CUR_HIGH 2'h3
`define TCCD_CUR_RESET 2'h1

// Attach thresholds used while toggling as source
`define TCCD_DAC_RD_STD 6'h26
`define TCCD_DAC_RD_HIGH 6'h3E
`define TCCD_DAC_RESET 6'h00

// Resolved toggle outcomes
`define TCCD_RES_NONE 3'h0
`define TCCD_RES_SRC_CC1 3'h1
`define TCCD_RES_SRC_CC2 3'h2
`define TCCD_RES_SNK_CC1 3'h5
`define TCCD_RES_SNK_CC2 3'h6

`endif

/* common/tccd_pkg.sv */
package tccd_pkg;

  typedef enum logic [1:0] {
    TCCD_MODE_DRP,
    TCCD_MODE_SRC_ONLY,
    TCCD_MODE_SNK_ONLY
  } tccd_mode_t;

  typedef enum logic [1:0] {
    TCCD_ST_OFF,
    TCCD_ST_SRC,
    TCCD_ST_SNK,
    TCCD_ST_DONE
  } tccd_state_t;

endpackage : tccd_pkg

/* logic/tccd_sync.sv */
`timescale 1ns/1ps
`include "tccd_map.svh"

module tccd_sync (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [`TCCD_SYNC_W-1:0] async_i,
  output logic [`TCCD_SYNC_W-1:0] stage2_o,
  output logic [`TCCD_SYNC_W-1:0] stage3_o
);

  logic [`TCCD_SYNC_W-1:0] stage1;

  genvar g;
  generate
    for (g = 0; g < `TCCD_SYNC_W; g = g + 1) begin : g_bit
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          stage1[g] <= 1'b0;
          stage2_o[g] <= 1'b0;
          stage3_o[g] <= 1'b0;
        end else begin
          stage1[g] <= async_i[g];
          stage2_o[g] <= stage1[g];
          stage3_o[g] <= stage2_o[g];
        end
      end
    end
  endgenerate

endmodule : tccd_sync

/* logic/tccd_top.sv */
// What this block does
// - Three fixed CC comparators; any CC or DAC comparator change raises level and comp events.
// - Software sets a 6-bit DAC threshold for a finer CC comparator.
// - Fixed VBUS-valid comparator; DAC comparator can be switched onto VBUS.
// - After reset both CC pins float, no pull-up or pull-down.
// - Software-selected sink mode applies Rd pull-downs on CC pins.
// - Autonomous toggle drives pulls and measure selects, alternating source and sink.
// - Toggle may instead stay source-only or sink-only, polling both CC pins.
// - On resolution raise toggle-done and report role and orientation.
// - Toggle enable high runs autonomous toggle; low leaves control to software.
// - Sink side reports VBUS valid as status and change event.
// - Level status: 00 Ra, 01 default, 10 1.5 A, 11 with comp for 3 A.
// - As source, advertise the selected charging current on the pull-up.
// - Current changed before attach is presented on the next clock, without waiting for a partner to attach.
// - Current changed while attached switches the CC line immediately.
// - Source Rd attach test uses DAC 1.6 V, or 2.6 V for high current.
// - Source Ra shows by level and comp at current-dependent thresholds.
// - Active-low open-drain interrupt output prompts the processor.
`timescale 1ns/1ps
`include "tccd_map.svh"

module tccd_top (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic toggle_en_i,
  input wire tccd_pkg::tccd_mode_t toggle_mode_i,
  input wire logic [1:0] source_current_select_i,
  input wire logic pulldown_cc1_en_i,
  input wire logic pulldown_cc2_en_i,
  input wire logic pullup_cc1_en_i,
  input wire logic pullup_cc2_en_i,
  input wire logic measure_cc1_sel_i,
  input wire logic measure_cc2_sel_i,
  input wire logic measure_vbus_sel_i,
  input wire logic [5:0] dac_level_i,
  input wire logic [`TCCD_IRQ_W-1:0] irq_mask_i,
  input wire logic [`TCCD_IRQ_W-1:0] irq_clear_i,
  input wire logic [2:0] cmp_level_i,
  input wire logic cmp_dac_i,
  input wire logic cmp_vbus_i,
  output logic pulldown_cc1_en_o,
  output logic pulldown_cc2_en_o,
  output logic pullup_cc1_en_o,
  output logic pullup_cc2_en_o,
  output logic measure_cc1_sel_o,
  output logic measure_cc2_sel_o,
  output logic measure_vbus_sel_o,
  output logic [1:0] source_current_o,
  output logic [5:0] dac_level_o,
  output logic [1:0] cc_level_status_o,
  output logic comp_o,
  output logic vbus_valid_o,
  output logic [`TCCD_IRQ_W-1:0] irq_status_o,
  output logic [2:0] toggle_result_state_o,
  output logic int_n_o,
  output logic int_n_oe_o
);

  function automatic logic [1:0] level_code(input logic [2:0] therm);
    if (therm[2]) begin
      level_code = `TCCD_LVL_3A0;
    end else if (therm[1]) begin
      level_code = `TCCD_LVL_1A5;
    end else if (therm[0]) begin
      level_code = `TCCD_LVL_USB;
    end else begin
      level_code = `TCCD_LVL_RA;
    end
  endfunction : level_code

  logic [`TCCD_SYNC_W-1:0] syn2;
  logic [`TCCD_SYNC_W-1:0] syn3;
  logic [`TCCD_SYNC_W-1:0] filt;
  logic [`TCCD_SYNC_W-1:0] prev_filt;
  logic [1:0] level_now;
  tccd_pkg::tccd_state_t st;
  tccd_pkg::tccd_state_t next_st;
  logic [`TCCD_TMR_W-1:0] tmr;
  logic on_cc2;
  logic half_end;
  logic phase_end;
  logic hit;
  logic [2:0] next_result;
  logic [`TCCD_IRQ_W-1:0] evt;
  logic [5:0] src_thresh;

  tccd_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i({cmp_vbus_i, cmp_dac_i, cmp_level_i}),
    .stage2_o(syn2),
    .stage3_o(syn3)
  );

  // Accept a comparator change once two stages agree
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      filt <= '0;
      prev_filt <= '0;
    end else begin
      filt <= (syn2 & syn3) | (filt & (syn2 | syn3));
      prev_filt <= filt;
    end
  end

  assign level_now = level_code(filt[`TCCD_SYN_LVL_HI:`TCCD_SYN_LVL_LO]);

  // Status outputs
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cc_level_status_o <= `TCCD_LVL_RA;
      comp_o <= 1'b0;
      vbus_valid_o <= 1'b0;
    end else begin
      cc_level_status_o <= level_now;
      comp_o <= filt[`TCCD_SYN_DAC];
      vbus_valid_o <= filt[`TCCD_SYN_VBUS];
    end
  end

  // Attach threshold while toggling as source
  assign src_thresh = (source_current_select_i == `TCCD_CUR_HIGH) ?
    `TCCD_DAC_RD_HIGH : `TCCD_DAC_RD_STD;

  // Toggle timer and phase bookkeeping
  assign half_end = (tmr == `TCCD_TMR_W'(`TCCD_HALF_CYC - 1));
  assign phase_end = (tmr == `TCCD_TMR_W'(`TCCD_PHASE_CYC - 1));
  assign hit = (st == tccd_pkg::TCCD_ST_SRC) ? !filt[`TCCD_SYN_DAC] :
    (level_now != `TCCD_LVL_RA);

  always_comb begin
    next_st = st;
    next_result = toggle_result_state_o;
    unique case (st)
      tccd_pkg::TCCD_ST_OFF: begin
        next_result = `TCCD_RES_NONE;
        if (toggle_en_i) begin
          if (toggle_mode_i == tccd_pkg::TCCD_MODE_SNK_ONLY) begin
            next_st = tccd_pkg::TCCD_ST_SNK;
          end else begin
            next_st = tccd_pkg::TCCD_ST_SRC;
          end
        end
      end
      tccd_pkg::TCCD_ST_SRC, tccd_pkg::TCCD_ST_SNK: begin
        if ((half_end || phase_end) && hit) begin
          next_st = tccd_pkg::TCCD_ST_DONE;
          if (st == tccd_pkg::TCCD_ST_SRC) begin
            next_result = on_cc2 ? `TCCD_RES_SRC_CC2 : `TCCD_RES_SRC_CC1;
          end else begin
            next_result = on_cc2 ? `TCCD_RES_SNK_CC2 : `TCCD_RES_SNK_CC1;
          end
        end else if (phase_end &&
                     toggle_mode_i == tccd_pkg::TCCD_MODE_DRP) begin
          next_st = (st == tccd_pkg::TCCD_ST_SRC) ?
            tccd_pkg::TCCD_ST_SNK : tccd_pkg::TCCD_ST_SRC;
        end else if (phase_end &&
                     toggle_mode_i == tccd_pkg::TCCD_MODE_SRC_ONLY) begin
          next_st = tccd_pkg::TCCD_ST_SRC;
        end else if (phase_end) begin
          next_st = tccd_pkg::TCCD_ST_SNK;
        end
        if (!toggle_en_i) begin
          next_st = tccd_pkg::TCCD_ST_OFF;
        end
      end
      tccd_pkg::TCCD_ST_DONE: begin
        if (!toggle_en_i) begin
          next_st = tccd_pkg::TCCD_ST_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st <= tccd_pkg::TCCD_ST_OFF;
      toggle_result_state_o <= `TCCD_RES_NONE;
    end else begin
      st <= next_st;
      toggle_result_state_o <= next_result;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tmr <= '0;
      on_cc2 <= 1'b0;
    end else if (st != next_st || phase_end) begin
      tmr <= '0;
      on_cc2 <= 1'b0;
    end else begin
      tmr <= tmr + `TCCD_TMR_W'(1);
      on_cc2 <= on_cc2 | half_end;
    end
  end

  // Terminations and measurement selects
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pulldown_cc1_en_o <= 1'b0;
      pulldown_cc2_en_o <= 1'b0;
      pullup_cc1_en_o <= 1'b0;
      pullup_cc2_en_o <= 1'b0;
      measure_cc1_sel_o <= 1'b0;
      measure_cc2_sel_o <= 1'b0;
      measure_vbus_sel_o <= 1'b0;
      dac_level_o <= `TCCD_DAC_RESET;
    end else begin
      unique case (st)
        tccd_pkg::TCCD_ST_OFF: begin
          pulldown_cc1_en_o <= pulldown_cc1_en_i;
          pulldown_cc2_en_o <= pulldown_cc2_en_i;
          pullup_cc1_en_o <= pullup_cc1_en_i;
          pullup_cc2_en_o <= pullup_cc2_en_i;
          measure_cc1_sel_o <= measure_cc1_sel_i;
          measure_cc2_sel_o <= measure_cc2_sel_i;
          measure_vbus_sel_o <= measure_vbus_sel_i;
          dac_level_o <= dac_level_i;
        end
        tccd_pkg::TCCD_ST_SRC, tccd_pkg::TCCD_ST_SNK: begin
          pulldown_cc1_en_o <= (st == tccd_pkg::TCCD_ST_SNK);
          pulldown_cc2_en_o <= (st == tccd_pkg::TCCD_ST_SNK);
          pullup_cc1_en_o <= (st == tccd_pkg::TCCD_ST_SRC);
          pullup_cc2_en_o <= (st == tccd_pkg::TCCD_ST_SRC);
          measure_cc1_sel_o <= !on_cc2;
          measure_cc2_sel_o <= on_cc2;
          measure_vbus_sel_o <= 1'b0;
          dac_level_o <= src_thresh;
        end
        tccd_pkg::TCCD_ST_DONE: begin
          pulldown_cc1_en_o <= toggle_result_state_o == `TCCD_RES_SNK_CC1;
          pulldown_cc2_en_o <= toggle_result_state_o == `TCCD_RES_SNK_CC2;
          pullup_cc1_en_o <= toggle_result_state_o == `TCCD_RES_SRC_CC1;
          pullup_cc2_en_o <= toggle_result_state_o == `TCCD_RES_SRC_CC2;
          measure_cc1_sel_o <= toggle_result_state_o == `TCCD_RES_SRC_CC1 ||
            toggle_result_state_o == `TCCD_RES_SNK_CC1;
          measure_cc2_sel_o <= toggle_result_state_o == `TCCD_RES_SRC_CC2 ||
            toggle_result_state_o == `TCCD_RES_SNK_CC2;
          measure_vbus_sel_o <= 1'b0;
          dac_level_o <= src_thresh;
        end
      endcase
    end
  end

  // Advertised current follows the select at once, attached or not
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      source_current_o <= `TCCD_CUR_RESET;
    end else begin
      source_current_o <= source_current_select_i;
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  always_comb begin
    evt = '0;
    evt[`TCCD_IRQ_LEVEL] = (filt[`TCCD_SYN_LVL_HI:`TCCD_SYN_LVL_LO] !=
      prev_filt[`TCCD_SYN_LVL_HI:`TCCD_SYN_LVL_LO]) ||
      (filt[`TCCD_SYN_DAC] != prev_filt[`TCCD_SYN_DAC]);
    evt[`TCCD_IRQ_COMP] = evt[`TCCD_IRQ_LEVEL];
    evt[`TCCD_IRQ_VBUS] = filt[`TCCD_SYN_VBUS] !=
      prev_filt[`TCCD_SYN_VBUS];
    evt[`TCCD_IRQ_TOGDONE] = (next_st == tccd_pkg::TCCD_ST_DONE) &&
      (st != tccd_pkg::TCCD_ST_DONE);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status_o <= '0;
    end else begin
      irq_status_o <= (irq_status_o & ~irq_clear_i) | evt;
    end
  end

  // Open-drain interrupt pin, pulled low while anything unmasked pends
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      int_n_o <= 1'b0;
      int_n_oe_o <= 1'b0;
    end else begin
      int_n_o <= 1'b0;
      int_n_oe_o <= |(irq_status_o & ~irq_mask_i);
    end
  end

  // Checks
  chk_float_reset: assert property (
    @(posedge clk_sys_i) $fell(rst_i) |->
      !pullup_cc1_en_o && !pullup_cc2_en_o &&
      !pulldown_cc1_en_o && !pulldown_cc2_en_o)
    else $error("CC pins not floating after reset");

  chk_sink_rd: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (st == tccd_pkg::TCCD_ST_OFF && pulldown_cc1_en_i) |=>
      pulldown_cc1_en_o)
    else $error("Sink pull-down not applied");

  chk_toggle_pulls: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (st == tccd_pkg::TCCD_ST_SNK && $past(st) == tccd_pkg::TCCD_ST_SNK) |->
      pulldown_cc1_en_o && pulldown_cc2_en_o && !pullup_cc1_en_o)
    else $error("Sink phase terminations wrong");

  chk_src_only: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (toggle_mode_i == tccd_pkg::TCCD_MODE_SRC_ONLY &&
     st == tccd_pkg::TCCD_ST_SRC && toggle_en_i) |=>
      st != tccd_pkg::TCCD_ST_SNK)
    else $error("Source-only toggle entered sink phase");

  chk_done_event: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (st == tccd_pkg::TCCD_ST_DONE && $past(st) != tccd_pkg::TCCD_ST_DONE)
      |-> irq_status_o[`TCCD_IRQ_TOGDONE] &&
      toggle_result_state_o != `TCCD_RES_NONE)
    else $error("Toggle done without event or result");

  chk_manual_ctl: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (!toggle_en_i && st == tccd_pkg::TCCD_ST_OFF) [*2] |->
      pullup_cc2_en_o == $past(pullup_cc2_en_i))
    else $error("Manual pull-up not followed");

  chk_level_event: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    $changed(cc_level_status_o) |->
      irq_status_o[`TCCD_IRQ_LEVEL] && irq_status_o[`TCCD_IRQ_COMP])
    else $error("Level change raised no event");

  chk_vbus_event: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    $changed(vbus_valid_o) |-> ##[0:1] irq_status_o[`TCCD_IRQ_VBUS])
    else $error("VBUS change raised no event");

  chk_current_now: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    $changed(source_current_select_i) |=>
      source_current_o == $past(source_current_select_i))
    else $error("Advertised current not updated");

  chk_int_hold: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (|(irq_status_o & ~irq_mask_i)) [*2] |-> int_n_oe_o && !int_n_o)
    else $error("Interrupt released while pending");

endmodule : tccd_top

/* tb/tccd_partner.sv */
`timescale 1ns/1ps

module tccd_partner (
  input wire logic pu1_i,
  input wire logic pu2_i,
  input wire logic pd1_i,
  input wire logic pd2_i,
  input wire logic m2_i,
  input wire logic mv_i,
  input wire logic [1:0] kind_i,
  input wire logic [1:0] adv_i,
  input wire logic on_cc2_i,
  output logic [2:0] cmp_level_o,
  output logic cmp_dac_o,
  output logic cmp_vbus_o
);
  logic hit;
  logic pu;
  logic pd;

  assign hit = (m2_i == on_cc2_i);
  assign pu = m2_i ? pu2_i : pu1_i;
  assign pd = m2_i ? pd2_i : pd1_i;
  // Kind 1 is a sink with Rd, kind 2 a source with VBUS
  // Kind 3 is an Ra load
  assign cmp_vbus_o = (kind_i == 2'h2);

  always_comb begin
    cmp_level_o = 3'h0;
    cmp_dac_o = 1'b0;
    if (mv_i) begin
      cmp_dac_o = cmp_vbus_o;
    end else if (hit && kind_i == 2'h1 && pu) begin
      cmp_level_o = 3'h3;
      cmp_dac_o = 1'b0;
    end else if (hit && kind_i == 2'h2 && pd) begin
      cmp_level_o = {adv_i == 2'h3, adv_i[1], 1'b1};
    end else if (hit && kind_i == 2'h3 && pu) begin
      cmp_level_o = (adv_i == 2'h3) ? 3'h3 : 3'h0;
    end else if (pu) begin
      cmp_level_o = 3'h7;
      cmp_dac_o = 1'b1;
    end
  end
endmodule : tccd_partner

/* tb/tb.sv */
`timescale 1ns/1ps
`include "tccd_map.svh"

module tb;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ten = 1'b0;
  tccd_pkg::tccd_mode_t mode = tccd_pkg::TCCD_MODE_DRP;
  logic [1:0] cur = 2'h1;
  logic pd1 = 1'b0, pd2 = 1'b0, pu1 = 1'b0, pu2 = 1'b0;
  logic m1 = 1'b0, m2 = 1'b0, mv = 1'b0;
  logic [5:0] dac = 6'h00;
  logic [3:0] mask = 4'h0, clr = 4'h0;
  logic [1:0] kind = 2'h0, adv = 2'h1;
  logic on2 = 1'b0;
  logic [2:0] lvl;
  logic cdac, cvb;
  logic o_pd1, o_pd2, o_pu1, o_pu2, o_m1, o_m2, o_mv, o_comp, o_vb;
  logic o_int, o_oe;
  logic [1:0] o_cur, o_st;
  logic [5:0] o_dac;
  logic [3:0] o_irq;
  logic [2:0] o_res;
  int failures = 0;
  int num_checks = 0;

  always #4 clk_sys_i = ~clk_sys_i;

  tccd_top u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .toggle_en_i(ten), .toggle_mode_i(mode),
    .source_current_select_i(cur), .pulldown_cc1_en_i(pd1),
    .pulldown_cc2_en_i(pd2), .pullup_cc1_en_i(pu1),
    .pullup_cc2_en_i(pu2), .measure_cc1_sel_i(m1),
    .measure_cc2_sel_i(m2), .measure_vbus_sel_i(mv),
    .dac_level_i(dac), .irq_mask_i(mask), .irq_clear_i(clr),
    .cmp_level_i(lvl), .cmp_dac_i(cdac), .cmp_vbus_i(cvb),
    .pulldown_cc1_en_o(o_pd1), .pulldown_cc2_en_o(o_pd2),
    .pullup_cc1_en_o(o_pu1), .pullup_cc2_en_o(o_pu2),
    .measure_cc1_sel_o(o_m1), .measure_cc2_sel_o(o_m2),
    .measure_vbus_sel_o(o_mv), .source_current_o(o_cur),
    .dac_level_o(o_dac), .cc_level_status_o(o_st), .comp_o(o_comp),
    .vbus_valid_o(o_vb), .irq_status_o(o_irq),
    .toggle_result_state_o(o_res), .int_n_o(o_int),
    .int_n_oe_o(o_oe));

  tccd_partner u_partner (.pu1_i(o_pu1), .pu2_i(o_pu2), .pd1_i(o_pd1),
    .pd2_i(o_pd2), .m2_i(o_m2), .mv_i(o_mv), .kind_i(kind),
    .adv_i(adv), .on_cc2_i(on2), .cmp_level_o(lvl),
    .cmp_dac_o(cdac), .cmp_vbus_o(cvb));

  task report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc

  task look(input int n);
    cyc(n);
    @(negedge clk_sys_i);
  endtask : look

  task clear_all;
    cyc(1);
    clr <= 4'hF;
    cyc(1);
    clr <= 4'h0;
    look(2);
  endtask : clear_all

  task wait_irq(input int b);
    int k;
    for (k = 0; k < 10000 && o_irq[b] !== 1'b1; k++) begin
      @(negedge clk_sys_i);
    end
    if (k == 10000) begin
      failures++;
      $display("ERROR irq wait expected 1 seen 0");
      report_and_stop();
    end
  endtask : wait_irq

  task t_reset;
    chk("pulls", {o_pd1, o_pd2, o_pu1, o_pu2}, 8'h00);
    chk("current", o_cur, 8'h01);
    chk("int oe", o_oe, 8'h00);
  endtask : t_reset

  task t_manual;
    cyc(1);
    pd1 <= 1'b1;
    pd2 <= 1'b1;
    m2 <= 1'b1;
    look(1);
    chk("pulldowns", {o_pd1, o_pd2, o_pu1, o_pu2}, 8'h0C);
    chk("measure_cc2_sel", o_m2, 8'h01);
    cyc(1);
    pd2 <= 1'b0;
    m2 <= 1'b0;
    m1 <= 1'b1;
    pu2 <= 1'b1;
    look(1);
    chk("manual pu2", {o_pd2, o_pu2, o_m1, o_m2}, 8'h06);
    cyc(1);
    pu2 <= 1'b0;
  endtask : t_manual

  task t_level;
    cyc(1);
    kind <= 2'h0;
    look(8);
    chk("level ra", o_st, 8'h00);
    for (int a = 1; a < 4; a++) begin
      clear_all();
      cyc(1);
      kind <= 2'h2;
      adv <= 2'(a);
      look(8);
      chk("level", o_st, 8'(a));
      chk("lvl comp irq", o_irq[1:0], 8'h03);
      chk("vbus ok", o_vb, 8'h01);
    end
  endtask : t_level

  task t_dac;
    cyc(1);
    dac <= 6'h34;
    mv <= 1'b1;
    look(8);
    chk("dac", o_dac, 8'h34);
    chk("measure_vbus_sel", o_mv, 8'h01);
    chk("comp vbus", o_comp, 8'h01);
    cyc(1);
    mv <= 1'b0;
    look(8);
    chk("comp 3a", {o_st, o_comp}, 8'h06);
  endtask : t_dac

  task t_irq;
    clear_all();
    chk("int idle", o_oe, 8'h00);
    cyc(1);
    kind <= 2'h0;
    look(8);
    chk("vbus gone", {o_vb, o_irq[2]}, 8'h01);
    chk("int", {o_oe, o_int}, 8'h02);
    cyc(1);
    mask <= 4'hF;
    look(2);
    chk("int masked", o_oe, 8'h00);
    cyc(1);
    mask <= 4'hB;
    look(2);
    chk("int unmask", o_oe, 8'h01);
    clear_all();
    chk("irq clr", {o_irq, 3'h0, o_oe}, 8'h00);
    cyc(1);
    mask <= 4'h0;
  endtask : t_irq

  task t_cur;
    for (int a = 1; a < 4; a++) begin
      cyc(1);
      cur <= 2'(a);
      look(1);
      chk("current", o_cur, 8'(a));
    end
  endtask : t_cur

  task t_ra;
    cyc(1);
    pu1 <= 1'b1;
    m1 <= 1'b1;
    kind <= 2'h3;
    adv <= 2'h3;
    dac <= 6'h13;
    look(8);
    chk("ra high", {o_st, o_comp}, 8'h04);
    cyc(1);
    adv <= 2'h1;
    cur <= 2'h1;
    look(8);
    chk("ra default", {o_st, o_comp}, 8'h00);
    cyc(1);
    pu1 <= 1'b0;
  endtask : t_ra

  task t_tog_src;
    cyc(1);
    pd1 <= 1'b0;
    m1 <= 1'b0;
    kind <= 2'h0;
    on2 <= 1'b1;
    cur <= 2'h3;
    mode <= tccd_pkg::TCCD_MODE_SRC_ONLY;
    clear_all();
    cyc(1);
    ten <= 1'b1;
    look(10);
    chk("src pulls", {o_pu1, o_pu2, o_m1}, 8'h07);
    chk("src dac", o_dac, 8'(`TCCD_DAC_RD_HIGH));
    look(`TCCD_PHASE_CYC);
    chk("src only", {o_pd1, o_pd2, o_pu1, o_pu2, o_m1}, 8'h07);
    cyc(1);
    kind <= 2'h1;
    wait_irq(3);
    look(2);
    chk("res", o_res, 8'(`TCCD_RES_SRC_CC2));
    chk("kept pull", {o_pu1, o_pu2}, 8'h01);
    chk("cur kept", o_cur, 8'h03);
    cyc(1);
    cur <= 2'h2;
    look(1);
    chk("cur now", o_cur, 8'h02);
    cyc(1);
    ten <= 1'b0;
    look(2);
    chk("res off", o_res, 8'(`TCCD_RES_NONE));
  endtask : t_tog_src

  task t_tog_snk;
    cyc(1);
    kind <= 2'h2;
    on2 <= 1'b0;
    adv <= 2'h1;
    cur <= 2'h1;
    mode <= tccd_pkg::TCCD_MODE_SNK_ONLY;
    clear_all();
    cyc(1);
    ten <= 1'b1;
    look(10);
    chk("snk no pu", {o_pu1, o_pu2}, 8'h00);
    wait_irq(3);
    look(2);
    chk("res", o_res, 8'(`TCCD_RES_SNK_CC1));
    chk("kept pd", o_pd1, 8'h01);
    cyc(1);
    ten <= 1'b0;
    look(2);
    chk("res off", o_res, 8'(`TCCD_RES_NONE));
  endtask : t_tog_snk

  task t_tog_drp;
    cyc(1);
    mode <= tccd_pkg::TCCD_MODE_DRP;
    clear_all();
    cyc(1);
    ten <= 1'b1;
    look(10);
    chk("drp src", {o_pu1, o_pu2, o_pd1}, 8'h06);
    chk("drp dac", o_dac, 8'(`TCCD_DAC_RD_STD));
    wait_irq(3);
    look(2);
    chk("drp res", o_res, 8'(`TCCD_RES_SNK_CC1));
    cyc(1);
    ten <= 1'b0;
    look(2);
  endtask : t_tog_drp

  initial begin
    cyc(2);
    rst_i <= 1'b0;
    look(1);
    t_reset();
    t_manual();
    t_level();
    t_dac();
    t_irq();
    t_cur();
    t_ra();
    t_tog_src();
    t_tog_snk();
    t_tog_drp();
    report_and_stop();
  end
endmodule : tb
